// >>> hw/gpp_port.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - All pin interrupt conditions merge into one port interrupt request.
// - Edge interrupts stay latched until software clears them.
// - Sense bit clear selects edge detection, set selects level detection.
// - Both-edges bit set detects rising and falling, ignoring polarity.
// - Polarity clear means low/falling, set means high/rising.
// - Mask bit clear blocks the pin from the interrupt line.
// - Raw status shows detected conditions regardless of mask.
// - Masked status shows only conditions passed by the mask.
// - Writing one to interrupt clear clears that pin; zero does nothing.
// - Port B bit 4 unmasked event also pulses the converter trigger.
// - Alternate select set gives the peripheral the pin, else software data.
// - Protected alternate bits change only when unlocked and committed.
// - Protection covers only port B bit 7 and port C bits 3..0.
// - Pad settings: 2/4/8 mA, open drain, pulls, slew, digital enable.
// - Non-debug pins reset undriven with select, enable and pulls cleared.
// - Read-only identification values mark the block as general I/O.
// - Direction clear makes input capturing pad, set makes output driving.
// - Debug pins reset with select, digital enable and pull-up set.
module gpp_port #(
  parameter logic [2:0] P_PORT_ID = gpp_pkg::PORT_A
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic [7:0]  I_PIN,
  output logic      [7:0]  O_PIN_OUT,
  output logic      [7:0]  O_PIN_OE,
  input  wire logic [7:0]  I_PERIPH_OUT,
  input  wire logic [7:0]  I_PERIPH_OE,
  output logic      [7:0]  O_PERIPH_IN,
  output logic      [7:0]  O_PULL_UP,
  output logic      [7:0]  O_PULL_DOWN,
  output logic      [7:0]  O_DRIVE_LOW,
  output logic      [7:0]  O_DRIVE_MID,
  output logic      [7:0]  O_DRIVE_HIGH,
  output logic      [7:0]  O_SLEW_LIMIT,
  output logic      [7:0]  O_OPEN_DRAIN,
  output logic      [7:0]  O_DIGITAL_EN,
  output logic             O_IRQ,
  output logic             O_CONV_TRIG
);
  // Protected pin set and debug reset values per port
  localparam logic [7:0] PROT = (P_PORT_ID == gpp_pkg::PORT_B) ? gpp_pkg::PROT_B :
                                (P_PORT_ID == gpp_pkg::PORT_C) ? gpp_pkg::PROT_C :
                                gpp_pkg::PROT_NONE;
  localparam logic       HAS_TRIG = (P_PORT_ID == gpp_pkg::PORT_B);
  logic [7:0]  pin_data_ff, pin_direction_ff, irq_sense_select_ff, irq_both_edges_ff;
  logic [7:0]  irq_polarity_ff, irq_mask_ff, irq_raw_status_ff, nxt_irq_raw_status;
  logic [7:0]  alt_function_select_ff, commit_enable_ff;
  logic        config_lock_ff;
  logic [7:0]  sync1_ff, sync2_ff, sync3_ff, filt_ff, prev_ff, nxt_filt, agree;
  logic [7:0]  pin_val, rise, fall, edge_hit, lvl_hit, irq_clear, afsel_we;
  logic [31:0] nxt_rdata;
  logic        nxt_err, wr_acc, setup;
  logic [7:0]  nxt_oe, nxt_out;
  assign setup  = I_PSEL && !I_PENABLE;
  assign wr_acc = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  // Pad input synchroniser, third stage confirms second
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync1_ff <= gpp_pkg::RST_ZERO;
      sync2_ff <= gpp_pkg::RST_ZERO;
      sync3_ff <= gpp_pkg::RST_ZERO;
    end else begin
      sync1_ff <= I_PIN;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Accept a new pin level once two stages agree
  assign agree    = ~(sync2_ff ^ sync3_ff);
  assign nxt_filt = (agree & sync3_ff) | (~agree & filt_ff);
  assign pin_val  = filt_ff & O_DIGITAL_EN; // Disabled pads read zero

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      filt_ff <= gpp_pkg::RST_ZERO;
      prev_ff <= gpp_pkg::RST_ZERO;
    end else begin
      filt_ff <= nxt_filt;
      prev_ff <= pin_val;
    end
  end
  // Write-one-to-clear strobe for latched interrupts
  assign irq_clear = (wr_acc && I_PADDR == gpp_pkg::OFF_ICR) ? I_PWDATA[7:0]
                                                             : gpp_pkg::RST_ZERO;
  // Per-pin condition detection
  genvar g;
  generate
    for (g = 0; g < gpp_pkg::PIN_W; g++) begin : g_det
      assign rise[g]     = pin_val[g] & ~prev_ff[g];
      assign fall[g]     = ~pin_val[g] & prev_ff[g];
      assign edge_hit[g] = irq_both_edges_ff[g] ? (rise[g] | fall[g])
                         : (irq_polarity_ff[g] ? rise[g] : fall[g]);
      assign lvl_hit[g]  = irq_polarity_ff[g] ? pin_val[g] : ~pin_val[g];
      // Level follows the pin; edge latches, set beats clear
      assign nxt_irq_raw_status[g] = irq_sense_select_ff[g] ? lvl_hit[g]
        : (edge_hit[g] | (irq_raw_status_ff[g] & ~irq_clear[g]));
      // Protected bits need unlock plus commit
      assign afsel_we[g] = ~PROT[g] | (~config_lock_ff & commit_enable_ff[g]);
    end
  endgenerate
  // Raw interrupt status
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_raw_status_ff <= gpp_pkg::RST_ZERO;
    end else begin
      irq_raw_status_ff <= nxt_irq_raw_status;
    end
  end

  // Port interrupt and converter trigger
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_IRQ       <= 1'b0;
      O_CONV_TRIG <= 1'b0;
    end else begin
      O_IRQ       <= |(irq_raw_status_ff & irq_mask_ff);
      O_CONV_TRIG <= HAS_TRIG && irq_mask_ff[gpp_pkg::TRIG_BIT]
                     && nxt_irq_raw_status[gpp_pkg::TRIG_BIT]
                     && !irq_raw_status_ff[gpp_pkg::TRIG_BIT];
    end
  end

  // Interrupt configuration registers
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_sense_select_ff <= gpp_pkg::RST_ZERO;
      irq_both_edges_ff   <= gpp_pkg::RST_ZERO;
      irq_polarity_ff     <= gpp_pkg::RST_ZERO;
      irq_mask_ff         <= gpp_pkg::RST_ZERO;
    end else if (wr_acc) begin
      if (I_PADDR == gpp_pkg::OFF_IS)  irq_sense_select_ff <= I_PWDATA[7:0];
      if (I_PADDR == gpp_pkg::OFF_IBE) irq_both_edges_ff   <= I_PWDATA[7:0];
      if (I_PADDR == gpp_pkg::OFF_IEV) irq_polarity_ff     <= I_PWDATA[7:0];
      if (I_PADDR == gpp_pkg::OFF_IM)  irq_mask_ff         <= I_PWDATA[7:0];
    end
  end

  // Data and direction; data write masked by address bits 9..2
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pin_data_ff      <= gpp_pkg::RST_ZERO;
      pin_direction_ff <= gpp_pkg::RST_ZERO;
    end else if (wr_acc) begin
      if (I_PADDR <= gpp_pkg::OFF_DATA_TOP)
        pin_data_ff <= (pin_data_ff & ~I_PADDR[9:2]) | (I_PWDATA[7:0] & I_PADDR[9:2]);
      if (I_PADDR == gpp_pkg::OFF_DIR) pin_direction_ff <= I_PWDATA[7:0];
    end
  end

  // Lock, commit and alternate select
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      config_lock_ff         <= gpp_pkg::RST_LOCKED;
      commit_enable_ff       <= ~PROT;
      alt_function_select_ff <= PROT;
    end else if (wr_acc) begin
      if (I_PADDR == gpp_pkg::OFF_LOCK)
        config_lock_ff <= (I_PWDATA != gpp_pkg::UNLOCK_KEY);
      if (I_PADDR == gpp_pkg::OFF_CR && !config_lock_ff)
        commit_enable_ff <= (commit_enable_ff & ~PROT) | (I_PWDATA[7:0] & PROT);
      if (I_PADDR == gpp_pkg::OFF_AFSEL)
        alt_function_select_ff <= (alt_function_select_ff & ~afsel_we)
                                | (I_PWDATA[7:0] & afsel_we);
    end
  end

  // Pad control registers; drive strengths exclude one another
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_DRIVE_LOW  <= gpp_pkg::RST_DR2;
      O_DRIVE_MID  <= gpp_pkg::RST_ZERO;
      O_DRIVE_HIGH <= gpp_pkg::RST_ZERO;
      O_OPEN_DRAIN <= gpp_pkg::RST_ZERO;
      O_PULL_UP    <= PROT;
      O_PULL_DOWN  <= gpp_pkg::RST_ZERO;
      O_SLEW_LIMIT <= gpp_pkg::RST_ZERO;
      O_DIGITAL_EN <= PROT;
    end else if (wr_acc) begin
      unique case (I_PADDR)
        gpp_pkg::OFF_DR2: begin
          O_DRIVE_LOW  <= I_PWDATA[7:0];
          O_DRIVE_MID  <= O_DRIVE_MID & ~I_PWDATA[7:0];
          O_DRIVE_HIGH <= O_DRIVE_HIGH & ~I_PWDATA[7:0];
        end
        gpp_pkg::OFF_DR4: begin
          O_DRIVE_MID  <= I_PWDATA[7:0];
          O_DRIVE_LOW  <= O_DRIVE_LOW & ~I_PWDATA[7:0];
          O_DRIVE_HIGH <= O_DRIVE_HIGH & ~I_PWDATA[7:0];
        end
        gpp_pkg::OFF_DR8: begin
          O_DRIVE_HIGH <= I_PWDATA[7:0];
          O_DRIVE_LOW  <= O_DRIVE_LOW & ~I_PWDATA[7:0];
          O_DRIVE_MID  <= O_DRIVE_MID & ~I_PWDATA[7:0];
        end
        gpp_pkg::OFF_ODR: O_OPEN_DRAIN <= I_PWDATA[7:0];
        gpp_pkg::OFF_PUR: O_PULL_UP    <= I_PWDATA[7:0];
        gpp_pkg::OFF_PDR: O_PULL_DOWN  <= I_PWDATA[7:0];
        gpp_pkg::OFF_SLR: O_SLEW_LIMIT <= I_PWDATA[7:0];
        gpp_pkg::OFF_DEN: O_DIGITAL_EN <= I_PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // Pin drive: software or peripheral, open drain only pulls low
  always_comb begin
    nxt_oe  = gpp_pkg::RST_ZERO;
    nxt_out = gpp_pkg::RST_ZERO;
    for (int i = 0; i < gpp_pkg::PIN_W; i++) begin
      if (alt_function_select_ff[i]) begin
        nxt_oe[i]  = I_PERIPH_OE[i];
        nxt_out[i] = I_PERIPH_OUT[i];
      end else begin
        nxt_oe[i]  = pin_direction_ff[i];
        nxt_out[i] = pin_data_ff[i];
      end
      if (O_OPEN_DRAIN[i]) begin
        nxt_oe[i]  = nxt_oe[i] & ~nxt_out[i];
        nxt_out[i] = 1'b0;
      end
      nxt_oe[i] = nxt_oe[i] & O_DIGITAL_EN[i];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PIN_OE    <= gpp_pkg::RST_ZERO;
      O_PIN_OUT   <= gpp_pkg::RST_ZERO;
      O_PERIPH_IN <= gpp_pkg::RST_ZERO;
    end else begin
      O_PIN_OE    <= nxt_oe;
      O_PIN_OUT   <= nxt_out;
      O_PERIPH_IN <= pin_val & alt_function_select_ff;
    end
  end

  // Read mux, evaluated in the setup cycle
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_err   = 1'b0;
    if (I_PADDR <= gpp_pkg::OFF_DATA_TOP) begin
      nxt_rdata[7:0] = ((pin_direction_ff & pin_data_ff) | (~pin_direction_ff & pin_val))
                       & I_PADDR[9:2];
    end else if (I_PADDR >= gpp_pkg::OFF_ID_LO && I_PADDR[1:0] == 2'h0) begin
      if (I_PADDR == gpp_pkg::OFF_PID0) nxt_rdata[7:0] = gpp_pkg::PERIPH_ID0;
      if (I_PADDR == gpp_pkg::OFF_CID0) nxt_rdata[7:0] = gpp_pkg::CELL_ID0;
    end else begin
      unique case (I_PADDR)
        gpp_pkg::OFF_DIR:   nxt_rdata[7:0] = pin_direction_ff;
        gpp_pkg::OFF_IS:    nxt_rdata[7:0] = irq_sense_select_ff;
        gpp_pkg::OFF_IBE:   nxt_rdata[7:0] = irq_both_edges_ff;
        gpp_pkg::OFF_IEV:   nxt_rdata[7:0] = irq_polarity_ff;
        gpp_pkg::OFF_IM:    nxt_rdata[7:0] = irq_mask_ff;
        gpp_pkg::OFF_RIS:   nxt_rdata[7:0] = irq_raw_status_ff;
        gpp_pkg::OFF_MIS:   nxt_rdata[7:0] = irq_raw_status_ff & irq_mask_ff;
        gpp_pkg::OFF_ICR:   nxt_rdata[7:0] = gpp_pkg::RST_ZERO;
        gpp_pkg::OFF_AFSEL: nxt_rdata[7:0] = alt_function_select_ff;
        gpp_pkg::OFF_DR2:   nxt_rdata[7:0] = O_DRIVE_LOW;
        gpp_pkg::OFF_DR4:   nxt_rdata[7:0] = O_DRIVE_MID;
        gpp_pkg::OFF_DR8:   nxt_rdata[7:0] = O_DRIVE_HIGH;
        gpp_pkg::OFF_ODR:   nxt_rdata[7:0] = O_OPEN_DRAIN;
        gpp_pkg::OFF_PUR:   nxt_rdata[7:0] = O_PULL_UP;
        gpp_pkg::OFF_PDR:   nxt_rdata[7:0] = O_PULL_DOWN;
        gpp_pkg::OFF_SLR:   nxt_rdata[7:0] = O_SLEW_LIMIT;
        gpp_pkg::OFF_DEN:   nxt_rdata[7:0] = O_DIGITAL_EN;
        gpp_pkg::OFF_LOCK:  nxt_rdata[0]   = config_lock_ff;
        gpp_pkg::OFF_CR:    nxt_rdata[7:0] = commit_enable_ff;
        default:            nxt_err        = 1'b1;
      endcase
    end
  end

  // APB answer: one wait-free access phase after setup
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= setup;
      O_PSLVERR <= setup && nxt_err;
      if (setup && !I_PWRITE) O_PRDATA <= nxt_rdata;
    end
  end

  // Checks; detection ones watch pin 2, which the interrupt scenarios drive
  property p_irq_line;
    @(posedge I_CLK) disable iff (!I_RSTN)
      ##1 (O_IRQ == |($past(irq_raw_status_ff & irq_mask_ff)));
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq not OR of masked status");
  property p_edge_hold;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (irq_raw_status_ff[2] && !irq_sense_select_ff[2] && !irq_clear[2]) |=> irq_raw_status_ff[2];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");
  property p_level_hit;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (irq_sense_select_ff[2] && irq_polarity_ff[2] && pin_val[2]) |=> irq_raw_status_ff[2];
  endproperty
  a_level_hit: assert property (p_level_hit) else $error("high level missed");
  property p_both_edges;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (!irq_sense_select_ff[2] && irq_both_edges_ff[2] && fall[2]) |=> irq_raw_status_ff[2];
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("falling edge missed");
  property p_rise_only;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (!irq_sense_select_ff[2] && !irq_both_edges_ff[2] && irq_polarity_ff[2] && fall[2]
       && !irq_raw_status_ff[2]) |=> !irq_raw_status_ff[2];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("wrong edge latched");
  property p_mis_read;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (setup && !I_PWRITE && I_PADDR == gpp_pkg::OFF_MIS)
      |=> (O_PRDATA[7:0] == $past(irq_raw_status_ff & irq_mask_ff));
  endproperty
  a_mis_read: assert property (p_mis_read) else $error("masked status wrong");
  property p_clear;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (irq_clear[2] && !irq_sense_select_ff[2] && !edge_hit[2]) |=> !irq_raw_status_ff[2];
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_trig;
    @(posedge I_CLK) disable iff (!I_RSTN)
      O_CONV_TRIG |-> (HAS_TRIG && $past(irq_mask_ff[gpp_pkg::TRIG_BIT])
                       && irq_raw_status_ff[gpp_pkg::TRIG_BIT]) ##1 !O_CONV_TRIG;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger without masked event");
  property p_afsel_lock;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (wr_acc && I_PADDR == gpp_pkg::OFF_AFSEL && config_lock_ff)
      |=> ((alt_function_select_ff & PROT) == $past(alt_function_select_ff & PROT));
  endproperty
  a_afsel_lock: assert property (p_afsel_lock) else $error("locked bit changed");
  property p_sw_drive;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (!alt_function_select_ff[0] && O_DIGITAL_EN[0] && !O_OPEN_DRAIN[0])
      |=> (O_PIN_OE[0] == $past(pin_direction_ff[0]));
  endproperty
  a_sw_drive: assert property (p_sw_drive) else $error("direction not applied");
  property p_alt_drive;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (alt_function_select_ff[0] && O_DIGITAL_EN[0] && !O_OPEN_DRAIN[0])
      |=> (O_PIN_OE[0] == $past(I_PERIPH_OE[0]) && O_PIN_OUT[0] == $past(I_PERIPH_OUT[0]));
  endproperty
  a_alt_drive: assert property (p_alt_drive) else $error("peripheral not routed");
endmodule // gpp_port

// >>> hw/gpp_pkg.sv
package gpp_pkg;
  // Port geometry and port identities
  localparam int unsigned PIN_W      = 8;
  localparam int unsigned ADDR_W     = 12;
  localparam logic [2:0]  PORT_A     = 3'h0;
  localparam logic [2:0]  PORT_B     = 3'h1;
  localparam logic [2:0]  PORT_C     = 3'h2;
  localparam int unsigned TRIG_BIT   = 4;
  localparam logic [7:0]  PROT_B     = 8'h80;
  localparam logic [7:0]  PROT_C     = 8'h0F;
  localparam logic [7:0]  PROT_NONE  = 8'h00;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_DATA_TOP = 12'h3FC;
  localparam logic [11:0] OFF_DIR    = 12'h400;
  localparam logic [11:0] OFF_IS     = 12'h404;
  localparam logic [11:0] OFF_IBE    = 12'h408;
  localparam logic [11:0] OFF_IEV    = 12'h40C;
  localparam logic [11:0] OFF_IM     = 12'h410;
  localparam logic [11:0] OFF_RIS    = 12'h414;
  localparam logic [11:0] OFF_MIS    = 12'h418;
  localparam logic [11:0] OFF_ICR    = 12'h41C;
  localparam logic [11:0] OFF_AFSEL  = 12'h420;
  localparam logic [11:0] OFF_DR2    = 12'h500;
  localparam logic [11:0] OFF_DR4    = 12'h504;
  localparam logic [11:0] OFF_DR8    = 12'h508;
  localparam logic [11:0] OFF_ODR    = 12'h50C;
  localparam logic [11:0] OFF_PUR    = 12'h510;
  localparam logic [11:0] OFF_PDR    = 12'h514;
  localparam logic [11:0] OFF_SLR    = 12'h518;
  localparam logic [11:0] OFF_DEN    = 12'h51C;
  localparam logic [11:0] OFF_LOCK   = 12'h520;
  localparam logic [11:0] OFF_CR     = 12'h524;
  localparam logic [11:0] OFF_ID_LO  = 12'hFD0;
  localparam logic [11:0] OFF_PID0   = 12'hFE0;
  localparam logic [11:0] OFF_CID0   = 12'hFF0;

  // Reset values
  localparam logic [7:0]  RST_ZERO   = 8'h00;
  localparam logic [7:0]  RST_DR2    = 8'hFF;
  localparam logic        RST_LOCKED = 1'b1;

  // Unlock key and identification bytes (values arbitrary)
  localparam logic [31:0] UNLOCK_KEY = 32'h0000C0DE;
  localparam logic [7:0]  PERIPH_ID0 = 8'h3C;
  localparam logic [7:0]  CELL_ID0   = 8'h96;
endpackage : gpp_pkg

// >>> tb/gpp_pad_model.sv
`timescale 1ns/1ps
module gpp_pad_model (
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  output logic      [7:0] o_pad
);
  // Port drive wins where enabled, else the held external level
  assign o_pad = (i_oe & i_out) | (~i_oe & i_ext);
endmodule // gpp_pad_model

// >>> tb/gpio_port_irq_mode_commit_tb.sv
`timescale 1ns/1ps
module gpio_port_irq_mode_commit_tb;
  typedef struct packed {
    logic        rd;
    logic [31:0] e;
    logic        er;
  } gpp_note_t;
  localparam logic [11:0] RA [9] = '{gpp_pkg::OFF_AFSEL, gpp_pkg::OFF_PUR, gpp_pkg::OFF_DEN,
    gpp_pkg::OFF_DR2, gpp_pkg::OFF_LOCK, gpp_pkg::OFF_CR, gpp_pkg::OFF_PID0, gpp_pkg::OFF_CID0,
    12'h600};
  localparam logic [31:0] RV [9] = '{32'h80, 32'h80, 32'h80, 32'hFF, 32'h1, 32'h7F,
    32'(gpp_pkg::PERIPH_ID0), 32'(gpp_pkg::CELL_ID0), 32'h0};
  // Columns: sense, both, polarity, start level, end level, expected status
  localparam logic [5:0]  TBL [8] = '{6'h0B, 6'h0C, 6'h05, 6'h02, 6'h13, 6'h1D, 6'h2B, 6'h25};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ext = 8'h00;
  logic [7:0]  per_out = 8'h00;
  logic [7:0]  per_oe = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, trig;
  logic [7:0]  pad, pin_out, pin_oe, pull_up, den, drv_lo, drv_hi;
  logic [7:0]  pull_dn, drv_mid, slew, odr, per_in;
  logic [31:0] seed = 32'h00002FFD;
  gpp_note_t   cur;
  gpp_note_t   note_q[$];
  int          failures = 0;
  int          check_count = 0;
  int          trig_cnt = 0;

  always #12.5 clk = ~clk; // Port clock runs before any access

  gpp_port #(.P_PORT_ID(gpp_pkg::PORT_B)) u_gpp_port (
    .I_CLK(clk), .I_RSTN(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PIN(pad), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
    .I_PERIPH_OUT(per_out), .I_PERIPH_OE(per_oe), .O_PERIPH_IN(per_in), .O_PULL_UP(pull_up),
    .O_PULL_DOWN(pull_dn), .O_DRIVE_LOW(drv_lo), .O_DRIVE_MID(drv_mid), .O_DRIVE_HIGH(drv_hi),
    .O_SLEW_LIMIT(slew), .O_OPEN_DRAIN(odr), .O_DIGITAL_EN(den), .O_IRQ(irq), .O_CONV_TRIG(trig));

  gpp_pad_model u_gpp_pad_model (.i_ext(ext), .i_out(pin_out), .i_oe(pin_oe), .o_pad(pad));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; reads note the expected data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic er = 1'b0);
    int n;
    n = 0;
    note_q.push_back('{rd: !w, e: d, er: er});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      stop_test();
    end
  endtask

  // Pad sync, status and request latency
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Interrupt setup with the pins masked meanwhile
  task automatic cfg(input logic [7:0] s, input logic [7:0] b, input logic [7:0] p,
                     input logic [7:0] m);
    apb(1'b1, gpp_pkg::OFF_IM, 32'h0);
    apb(1'b1, gpp_pkg::OFF_IS, {24'h0, s});
    apb(1'b1, gpp_pkg::OFF_IBE, {24'h0, b});
    apb(1'b1, gpp_pkg::OFF_IEV, {24'h0, p});
    apb(1'b1, gpp_pkg::OFF_ICR, 32'hFF);
    apb(1'b1, gpp_pkg::OFF_IM, {24'h0, m});
  endtask

  // Pairs each bus answer with the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && penable === 1'b1 && note_q.size() > 0) begin
      cur = note_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, cur.er});
      if (cur.rd) check("prdata", prdata, cur.e);
    end
  end

  // Converter trigger pulse count
  always @(posedge clk) begin
    if (trig === 1'b1) trig_cnt++;
  end

  initial begin
    logic [31:0] r;
    logic [5:0]  row;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    check("pull_up", {24'h0, pull_up}, 32'h80);
    check("den", {24'h0, den}, 32'h80);
    check("pin_oe", {24'h0, pin_oe}, 32'h0);
    check("pad_ctl", {pull_dn, drv_mid, slew, odr}, 32'h0);
    for (int i = 0; i < 9; i++) apb(1'b0, RA[i], RV[i], i == 8);
    apb(1'b1, gpp_pkg::OFF_DEN, 32'hFF);
    for (int i = 0; i < 8; i++) begin
      row = TBL[i];
      apb(1'b1, gpp_pkg::OFF_IM, 32'h0);
      ext <= {8{row[2]}} & 8'h14;
      settle();
      cfg({8{row[5]}} & 8'h14, {8{row[4]}} & 8'h14, {8{row[3]}} & 8'h14, 8'h14);
      ext <= {8{row[1]}} & 8'h14;
      settle();
      apb(1'b0, gpp_pkg::OFF_RIS, {24'h0, {8{row[0]}} & 8'h14});
      apb(1'b0, gpp_pkg::OFF_MIS, {24'h0, {8{row[0]}} & 8'h14});
      check("irq", {31'h0, irq}, {31'h0, row[0]});
    end
    check("trig", trig_cnt, 6);
    cfg(8'h00, 8'h00, 8'hFF, 8'h04);
    ext <= 8'h14;
    settle();
    ext <= 8'h00;
    settle();
    apb(1'b0, gpp_pkg::OFF_RIS, 32'h14);
    apb(1'b0, gpp_pkg::OFF_MIS, 32'h04);
    apb(1'b1, gpp_pkg::OFF_ICR, 32'hFB);
    apb(1'b0, gpp_pkg::OFF_RIS, 32'h04);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, gpp_pkg::OFF_ICR, 32'h04);
    apb(1'b0, gpp_pkg::OFF_RIS, 32'h00);
    check("irq", {31'h0, irq}, 32'h0);
    check("trig", trig_cnt, 6);
    apb(1'b1, gpp_pkg::OFF_AFSEL, 32'h01);
    apb(1'b0, gpp_pkg::OFF_AFSEL, 32'h81);
    apb(1'b1, gpp_pkg::OFF_LOCK, gpp_pkg::UNLOCK_KEY);
    apb(1'b0, gpp_pkg::OFF_LOCK, 32'h0);
    apb(1'b1, gpp_pkg::OFF_AFSEL, 32'h01);
    apb(1'b0, gpp_pkg::OFF_AFSEL, 32'h81);
    apb(1'b1, gpp_pkg::OFF_CR, 32'h80);
    apb(1'b0, gpp_pkg::OFF_CR, 32'hFF);
    apb(1'b1, gpp_pkg::OFF_AFSEL, 32'h01);
    apb(1'b0, gpp_pkg::OFF_AFSEL, 32'h01);
    apb(1'b1, gpp_pkg::OFF_LOCK, 32'h0);
    apb(1'b0, gpp_pkg::OFF_LOCK, 32'h1);
    seed = xs(seed);
    r = seed;
    per_out <= r[7:0];
    per_oe  <= r[15:8];
    apb(1'b1, gpp_pkg::OFF_DIR, 32'hFF);
    apb(1'b1, gpp_pkg::OFF_DATA_TOP, {24'h0, r[23:16]});
    settle();
    check("pin_out", {24'h0, pin_out}, {24'h0, r[23:17], r[0]});
    check("pin_oe", {24'h0, pin_oe}, {24'h0, 7'h7F, r[8]});
    seed = xs(seed);
    ext <= seed[7:0];
    apb(1'b1, gpp_pkg::OFF_DIR, 32'h00);
    settle();
    apb(1'b0, 12'h3F8, {24'h0, seed[7:1], 1'b0});
    check("per_in", {24'h0, per_in}, {31'h0, (r[8] ? r[0] : seed[0])});
    apb(1'b1, gpp_pkg::OFF_DR8, 32'h0F);
    @(posedge clk);
    check("drv_hi", {24'h0, drv_hi}, 32'h0F);
    check("drv_lo", {24'h0, drv_lo}, 32'hF0);
    check("drv_mid", {24'h0, drv_mid}, 32'h00);
    stop_test();
  end
endmodule // gpio_port_irq_mode_commit_tb
